// [logic/rrd_dispatch.sv]
// remote reset dispatcher: common reset, device clear, selected clear, interface clear
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module rrd_dispatch #(
   parameter int QW = rrd_pkg::QW
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic cmd_reset,
   input wire logic cmd_dcl,
   input wire logic cmd_sdc,
   input wire logic ifc_pin,
   output logic abort_ops,
   output logic flush_input,
   output logic bus_halt,
   output logic talk_addressed,
   output logic listen_addressed,
   output logic srq_out,
   output logic mav,
   output logic full_settling_trigger,
   output logic repetitive_retrigger,
   output logic display_locked
);
   ////////////////////////////////////////////////////////////////////////////
   // source decode
   logic ifc_s;
   logic do_rst;
   logic do_dev;
   logic do_ifc;
   logic [31:0] rd_q;
   rrd_mem_if mi ();

   rrd_sync2 #(.W(1)) u_ifc_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .async_in(ifc_pin),
      .sync_out(ifc_s)
   );

   rrd_cfg_mem u_cfg (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .m(mi.mem)
   );

   function automatic logic at(input logic strobe, input logic [7:0] a, input logic [7:0] off);
      return strobe && a == off;
   endfunction

   // each source is a separate term so that coincident ones simply add up
   assign do_rst = ce && cmd_reset;
   assign do_dev = ce && (cmd_dcl || (cmd_sdc && listen_addressed));
   assign do_ifc = ce && ifc_s;

   logic w_trig;
   logic w_disp;
   logic w_pend;
   logic w_opc;
   logic w_oq;
   logic w_ibuf;
   logic w_iface;
   logic w_misc;
   assign w_trig = at(reg_wr, reg_addr, rrd_pkg::A_TRIG);
   assign w_disp = at(reg_wr, reg_addr, rrd_pkg::A_DISP);
   assign w_pend = at(reg_wr, reg_addr, rrd_pkg::A_PEND);
   assign w_opc = at(reg_wr, reg_addr, rrd_pkg::A_OPC);
   assign w_oq = at(reg_wr, reg_addr, rrd_pkg::A_OQ);
   assign w_ibuf = at(reg_wr, reg_addr, rrd_pkg::A_IBUF);
   assign w_iface = at(reg_wr, reg_addr, rrd_pkg::A_IFACE);
   assign w_misc = at(reg_wr, reg_addr, rrd_pkg::A_MISC);

   ////////////////////////////////////////////////////////////////////////////
   // measurement triggering and display
   logic [3:0] screen_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         full_settling_trigger <= rrd_pkg::TRIG_DEF[0];
         repetitive_retrigger <= rrd_pkg::TRIG_DEF[1];
      end else if (ce) begin
         if (w_trig) begin
            full_settling_trigger <= reg_wdata[0];
            repetitive_retrigger <= reg_wdata[1];
         end else if (do_rst) begin
            full_settling_trigger <= rrd_pkg::TRIG_DEF[0];
            repetitive_retrigger <= rrd_pkg::TRIG_DEF[1];
         end
      end
   end

   // device and interface clear have no path into trigger or display
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         display_locked <= 1'b0;
         screen_q <= rrd_pkg::SCR_RX_TEST;
      end else if (ce) begin
         if (w_disp) begin
            display_locked <= reg_wdata[0];
            screen_q <= reg_wdata[7:4];
         end else if (do_rst) begin
            display_locked <= 1'b0;
            screen_q <= rrd_pkg::SCR_RX_TEST;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operations, commands in process, completion tracking
   logic [7:0] pend_q;
   logic [7:0] proc_q;
   logic [1:0] opc_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pend_q <= '0;
         proc_q <= '0;
      end else if (ce) begin
         if (w_pend) begin
            pend_q <= reg_wdata[7:0];
            proc_q <= reg_wdata[15:8];
         end else begin
            if (do_rst) begin
               pend_q <= '0;
            end
            if (do_dev) begin
               proc_q <= '0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         opc_q <= '0;
      end else if (ce) begin
         if (w_opc) begin
            opc_q <= reg_wdata[1:0];
         end else if (do_rst || do_dev) begin
            opc_q <= '0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         abort_ops <= 1'b0;
         flush_input <= 1'b0;
         bus_halt <= 1'b0;
      end else if (ce) begin
         abort_ops <= do_rst;
         flush_input <= do_dev;
         bus_halt <= do_ifc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // queues: only device clear empties buffers; error queue has no clear at all
   logic [QW-1:0] oq_q;
   logic [QW-1:0] eq_q;
   logic [QW-1:0] ibuf_q;
   logic [QW-1:0] oq_d;

   always_comb begin
      oq_d = oq_q;
      if (w_oq) begin
         oq_d = reg_wdata[QW-1:0];
      end else if (do_dev) begin
         oq_d = rrd_pkg::Q_EMPTY;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         oq_q <= rrd_pkg::Q_EMPTY;
         mav <= 1'b0;
      end else if (ce) begin
         oq_q <= oq_d;
         mav <= oq_d != rrd_pkg::Q_EMPTY;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ibuf_q <= rrd_pkg::Q_EMPTY;
      end else if (ce) begin
         if (w_ibuf) begin
            ibuf_q <= reg_wdata[QW-1:0];
         end else if (do_dev) begin
            ibuf_q <= rrd_pkg::Q_EMPTY;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         eq_q <= rrd_pkg::Q_EMPTY;
      end else if (ce && at(reg_wr, reg_addr, rrd_pkg::A_EQ)) begin
         eq_q <= reg_wdata[QW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus addressing and service request
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         talk_addressed <= 1'b0;
         listen_addressed <= 1'b0;
      end else if (ce) begin
         if (w_iface) begin
            talk_addressed <= reg_wdata[rrd_pkg::IF_TALK];
            listen_addressed <= reg_wdata[rrd_pkg::IF_LISTEN];
         end else if (do_ifc) begin
            talk_addressed <= 1'b0;
            listen_addressed <= 1'b0;
         end
      end
   end

   // no reset source appears here: a pending request survives all of them
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         srq_out <= 1'b0;
      end else if (ce && w_iface) begin
         srq_out <= reg_wdata[rrd_pkg::IF_SRQ];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status enables and transition filters: written by software only
   logic [31:0] ena_q;
   logic [31:0] ntf_q;
   logic [31:0] ptf_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ena_q <= '0;
         ntf_q <= '0;
         ptf_q <= '1;
      end else if (ce) begin
         if (at(reg_wr, reg_addr, rrd_pkg::A_ENA)) begin
            ena_q <= reg_wdata;
         end
         if (at(reg_wr, reg_addr, rrd_pkg::A_NTF)) begin
            ntf_q <= reg_wdata;
         end
         if (at(reg_wr, reg_addr, rrd_pkg::A_PTF)) begin
            ptf_q <= reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // print, test and storage defaults; channel standard kept in the same word
   logic [9:0] misc_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         misc_q <= rrd_pkg::MISC_DEF;
      end else if (ce) begin
         if (w_misc) begin
            misc_q <= reg_wdata[9:0];
         end else if (do_rst) begin
            misc_q <= rrd_pkg::MISC_DEF;
         end
      end
   end

   // default words only; the upper store words are never reloaded
   assign mi.load_def = do_rst;
   assign mi.we = ce && reg_wr && reg_addr[7:5] == rrd_pkg::CFG_SEL;
   assign mi.re = reg_rd && reg_addr[7:5] == rrd_pkg::CFG_SEL;
   assign mi.addr = reg_addr[4:2];
   assign mi.wdata = reg_wdata;

   ////////////////////////////////////////////////////////////////////////////
   // register read
   logic [31:0] status_w;
   always_comb begin
      status_w = '0;
      status_w[rrd_pkg::ST_PEND] = |pend_q;
      status_w[rrd_pkg::ST_OPC] = opc_q[0];
      status_w[rrd_pkg::ST_OPCQ] = opc_q[1];
      status_w[rrd_pkg::ST_MAV] = mav;
      status_w[rrd_pkg::ST_SRQ] = srq_out;
      status_w[rrd_pkg::ST_TALK] = talk_addressed;
      status_w[rrd_pkg::ST_LISTEN] = listen_addressed;
      status_w[rrd_pkg::ST_IFC] = bus_halt;
      status_w[rrd_pkg::ST_LOCK] = display_locked;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_q <= '0;
      end else if (ce) begin
         rd_q <= '0;
         if (reg_rd) begin
            unique case (reg_addr)
               rrd_pkg::A_STATUS: rd_q <= status_w;
               rrd_pkg::A_TRIG: rd_q <= {30'h0, repetitive_retrigger, full_settling_trigger};
               rrd_pkg::A_DISP: rd_q <= {24'h0, screen_q, 3'h0, display_locked};
               rrd_pkg::A_PEND: rd_q <= {16'h0, proc_q, pend_q};
               rrd_pkg::A_OPC: rd_q <= {30'h0, opc_q};
               rrd_pkg::A_ENA: rd_q <= ena_q;
               rrd_pkg::A_NTF: rd_q <= ntf_q;
               rrd_pkg::A_PTF: rd_q <= ptf_q;
               rrd_pkg::A_OQ: rd_q <= {24'h0, oq_q};
               rrd_pkg::A_EQ: rd_q <= {24'h0, eq_q};
               rrd_pkg::A_IBUF: rd_q <= {24'h0, ibuf_q};
               rrd_pkg::A_IFACE: rd_q <= {29'h0, srq_out, listen_addressed, talk_addressed};
               rrd_pkg::A_MISC: rd_q <= {22'h0, misc_q};
               default: rd_q <= '0;
            endcase
         end
      end
   end

   // store read data is zero unless the store was addressed
   assign reg_rdata = rd_q | mi.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_ifc_held;
      (ce && ifc_pin && !w_iface) [*3];
   endsequence

   sequence s_dev_clear;
      do_dev && !do_rst && !w_oq && !w_ibuf;
   endsequence

   chk_abort_pending: assert property (do_rst && !w_pend |=> abort_ops && pend_q == 8'h00)
      else $error("pending operations not aborted on common reset");

   chk_trig_default: assert property (do_rst && !w_trig |=>
      full_settling_trigger && repetitive_retrigger)
      else $error("trigger defaults not applied");

   chk_opc_drop: assert property ((do_rst || do_dev) && !w_opc |=> opc_q == 2'h0)
      else $error("operation complete tracking survived clear");

   chk_display_unlock: assert property (do_rst && !w_disp |=>
      !display_locked && screen_q == rrd_pkg::SCR_RX_TEST)
      else $error("display not unlocked on common reset");

   chk_srq_hold: assert property (srq_out && !w_iface |=> srq_out)
      else $error("pending service request lost");

   chk_filters_kept: assert property (!reg_wr |=> $stable(ena_q) && $stable(ntf_q)
      && $stable(ptf_q))
      else $error("enable or filter register changed without a write");

   chk_error_queue_kept: assert property (!at(reg_wr, reg_addr, rrd_pkg::A_EQ) |=>
      $stable(eq_q))
      else $error("error queue changed by a reset source");

   chk_dev_flush: assert property (s_dev_clear |=> oq_q == rrd_pkg::Q_EMPTY && !mav
      && ibuf_q == rrd_pkg::Q_EMPTY && flush_input)
      else $error("device clear did not flush buffers");

   chk_dev_keeps_cfg: assert property ((s_dev_clear and (!w_misc && !w_trig && !w_disp)) |=>
      $stable(misc_q) && $stable(full_settling_trigger) && $stable(display_locked))
      else $error("device clear altered configuration");

   chk_ifc_unaddress: assert property (s_ifc_held |=> !talk_addressed && !listen_addressed
      && bus_halt)
      else $error("interface clear left device addressed");

   chk_union_clear: assert property (do_rst && do_dev |=> abort_ops && flush_input)
      else $error("coincident sources not both applied");
endmodule

// [logic/rrd_pkg.sv]
// package: register map, field layout, reset defaults of the reset dispatcher
package rrd_pkg;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int QW = 8;
   // register byte offsets
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_TRIG = 8'h04;
   localparam logic [7:0] A_DISP = 8'h08;
   localparam logic [7:0] A_PEND = 8'h0c;
   localparam logic [7:0] A_OPC = 8'h10;
   localparam logic [7:0] A_ENA = 8'h14;
   localparam logic [7:0] A_NTF = 8'h18;
   localparam logic [7:0] A_PTF = 8'h1c;
   localparam logic [7:0] A_OQ = 8'h20;
   localparam logic [7:0] A_EQ = 8'h24;
   localparam logic [7:0] A_IBUF = 8'h28;
   localparam logic [7:0] A_IFACE = 8'h2c;
   localparam logic [7:0] A_MISC = 8'h30;
   localparam logic [7:0] A_CFG = 8'h40;
   localparam logic [2:0] CFG_SEL = 3'h2;
   // status bit positions
   localparam int ST_PEND = 0;
   localparam int ST_OPC = 1;
   localparam int ST_OPCQ = 2;
   localparam int ST_MAV = 3;
   localparam int ST_SRQ = 4;
   localparam int ST_TALK = 5;
   localparam int ST_LISTEN = 6;
   localparam int ST_IFC = 7;
   localparam int ST_LOCK = 8;
   // iface bits
   localparam int IF_TALK = 0;
   localparam int IF_LISTEN = 1;
   localparam int IF_SRQ = 2;
   // trigger: bit0 full settling, bit1 repetitive retrigger
   localparam logic [1:0] TRIG_DEF = 2'h3;
   localparam logic [3:0] SCR_RX_TEST = 4'h0;
   // misc: title blank, out to screen, continue on fail, continuous, internal store, chan std
   localparam logic [9:0] MISC_DEF = 10'h01f;
   localparam logic [QW-1:0] Q_EMPTY = 8'h00;
   // config words: base freq 800.000000 and duplex 45.000000 in 1e-6 MHz,
   // channel spacing 30.0000 in 1e-4 kHz, generator-analyzer offset zero
   localparam int CFG_DEPTH = 8;
   localparam int CFG_NDEF = 4;
   localparam logic [31:0] CFG_DEF [0:3] = '{32'h2faf0800, 32'h000493e0, 32'h02aea540,
      32'h00000000};
endpackage

// [logic/rrd_mem_if.sv]
// interface: configuration store access between dispatcher and store
`timescale 1ns/1ns
interface rrd_mem_if;
   logic we;
   logic re;
   logic load_def;
   logic [2:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport ctrl(output we, re, load_def, addr, wdata, input rdata);
   modport mem(input we, re, load_def, addr, wdata, output rdata);
endinterface

// [logic/rrd_sync2.sv]
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ns
module rrd_sync2 #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         sync_out <= '0;
      end else if (ce) begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// [logic/rrd_cfg_mem.sv]
// configuration field store with default load and registered read
`timescale 1ns/1ns
module rrd_cfg_mem #(
   parameter int DEPTH = rrd_pkg::CFG_DEPTH,
   parameter int NDEF = rrd_pkg::CFG_NDEF
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   rrd_mem_if.mem m
);
   logic [31:0] word_q [DEPTH];

   function automatic logic [31:0] def_word(input int i);
      return (i < NDEF) ? rrd_pkg::CFG_DEF[i] : 32'h00000000;
   endfunction

   for (genvar i = 0; i < DEPTH; i++) begin : g_word
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            word_q[i] <= def_word(i);
         end else if (ce) begin
            // software write beats a default load in the same cycle
            if (m.we && m.addr == 3'(i)) begin
               word_q[i] <= m.wdata;
            end else if (m.load_def && i < NDEF) begin
               word_q[i] <= def_word(i);
            end
         end
      end
   end

   // zero when not read so the top can merge it with its own read data
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         m.rdata <= '0;
      end else if (ce) begin
         m.rdata <= m.re ? word_q[m.addr] : '0;
      end
   end
endmodule

// [bench/rrd_ctrl_model.sv]
// bus controller model: decoded command pulses and the interface clear line
`timescale 1ns/1ns
module rrd_ctrl_model #(
   parameter int IFC_HOLD = 20
) (
   input wire logic sys_clk,
   output logic cmd_reset,
   output logic cmd_dcl,
   output logic cmd_sdc,
   output logic ifc_pin
);
   initial begin
      cmd_reset = 1'b0;
      cmd_dcl = 1'b0;
      cmd_sdc = 1'b0;
      ifc_pin = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // m = {common reset, device clear, selected clear}, one cycle wide
   task automatic send(input logic [2:0] m);
      @(posedge sys_clk);
      {cmd_reset, cmd_dcl, cmd_sdc} <= m;
      @(posedge sys_clk);
      {cmd_reset, cmd_dcl, cmd_sdc} <= 3'h0;
   endtask
   // full hold would be two million cycles; the device never times it, so it is cut short
   task automatic abort();
      @(posedge sys_clk);
      ifc_pin <= 1'b1;
      repeat (IFC_HOLD) @(posedge sys_clk);
      ifc_pin <= 1'b0;
   endtask
endmodule

// [bench/remote_reset_dispatch_tb.sv]
// self-checking bench for the remote reset dispatcher
`timescale 1ns/1ns
module remote_reset_dispatch_tb;
   logic sys_clk, rst, ce, reg_wr, reg_rd;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic cmd_reset, cmd_dcl, cmd_sdc, ifc_pin, abort_ops, flush_input, bus_halt;
   logic talk_addressed, listen_addressed, srq_out, mav;
   logic full_settling_trigger, repetitive_retrigger, display_locked;
   int n_fail = 0;
   int n_checks = 0;
   rrd_dispatch rrd_dispatch_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cmd_reset(cmd_reset), .cmd_dcl(cmd_dcl), .cmd_sdc(cmd_sdc),
      .ifc_pin(ifc_pin), .abort_ops(abort_ops), .flush_input(flush_input),
      .bus_halt(bus_halt), .talk_addressed(talk_addressed),
      .listen_addressed(listen_addressed), .srq_out(srq_out), .mav(mav),
      .full_settling_trigger(full_settling_trigger),
      .repetitive_retrigger(repetitive_retrigger), .display_locked(display_locked));
   rrd_ctrl_model rrd_ctrl_model_inst (.sys_clk(sys_clk), .cmd_reset(cmd_reset),
      .cmd_dcl(cmd_dcl), .cmd_sdc(cmd_sdc), .ifc_pin(ifc_pin));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk_w(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] reg %h expected %h seen %h", a, e, g);
      end
   endtask
   // order: abort flush halt talk listen srq mav lock full rep
   task automatic chk_f(input logic [9:0] e);
      logic [9:0] g;
      g = {abort_ops, flush_input, bus_halt, talk_addressed, listen_addressed, srq_out, mav,
         display_locked, full_settling_trigger, repetitive_retrigger};
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] flags expected %b seen %b", e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic wrs(input logic [7:0] a[$], input logic [31:0] d[$]);
      foreach (a[i]) wr(a[i], d[i]);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk_w(a, e, reg_rdata);
   endtask
   task automatic rchks(input logic [7:0] a[$], input logic [31:0] e[$]);
      foreach (a[i]) rchk(a[i], e[i]);
   endtask
   task automatic send_chk(input logic [2:0] m, input logic [9:0] e);
      rrd_ctrl_model_inst.send(m);
      @(negedge sys_clk);
      chk_f(e);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_rst();
      wrs('{rrd_pkg::A_PEND, rrd_pkg::A_OPC, rrd_pkg::A_TRIG, rrd_pkg::A_DISP, rrd_pkg::A_ENA,
         rrd_pkg::A_NTF, rrd_pkg::A_PTF, rrd_pkg::A_OQ, rrd_pkg::A_EQ, rrd_pkg::A_MISC,
         rrd_pkg::A_IFACE}, '{32'h305, 32'h3, 32'h0, 32'h51, 32'ha5, 32'h5a, 32'h0f, 32'h4,
         32'h2, 32'h300, 32'h4});
      for (int i = 0; i < 8; i++) wr(rrd_pkg::A_CFG + 8'(4 * i), 32'h100 + i);
      wr(rrd_pkg::A_STATUS, 32'h0); // read-only, ignored
      @(posedge sys_clk);
      ce <= 1'b0;
      send_chk(3'h4, 10'b0000011100);
      @(posedge sys_clk);
      ce <= 1'b1;
      send_chk(3'h4, 10'b1000011011);
      @(negedge sys_clk);
      chk_f(10'b0000011011);
      rchks('{rrd_pkg::A_PEND, rrd_pkg::A_OPC, rrd_pkg::A_TRIG, rrd_pkg::A_DISP}, '{32'h300,
         32'h0, 32'h3, 32'h0});
      rchks('{rrd_pkg::A_ENA, rrd_pkg::A_NTF, rrd_pkg::A_PTF}, '{32'ha5, 32'h5a, 32'h0f});
      rchks('{rrd_pkg::A_OQ, rrd_pkg::A_EQ, rrd_pkg::A_IFACE}, '{32'h4, 32'h2, 32'h4});
      rchk(rrd_pkg::A_MISC, 32'h1f);
      rchk(rrd_pkg::A_STATUS, 32'h18);
      for (int i = 0; i < 8; i++) rchk(rrd_pkg::A_CFG + 8'(4 * i),
         (i < 4) ? rrd_pkg::CFG_DEF[i] : 32'h100 + i);
   endtask
   task automatic t_clear(input logic [2:0] m);
      wrs('{rrd_pkg::A_IFACE, rrd_pkg::A_TRIG, rrd_pkg::A_DISP, rrd_pkg::A_PEND, rrd_pkg::A_OPC,
         rrd_pkg::A_OQ, rrd_pkg::A_EQ, rrd_pkg::A_IBUF, rrd_pkg::A_MISC, rrd_pkg::A_CFG},
         '{32'h6, 32'h1, 32'h31, 32'h305, 32'h3, 32'h5, 32'h7, 32'h6, 32'h2aa, 32'h11});
      send_chk(m, 10'b0100110110);
      rchks('{rrd_pkg::A_OQ, rrd_pkg::A_IBUF, rrd_pkg::A_PEND, rrd_pkg::A_OPC}, '{32'h0, 32'h0,
         32'h5, 32'h0});
      rchks('{rrd_pkg::A_EQ, rrd_pkg::A_TRIG, rrd_pkg::A_DISP}, '{32'h7, 32'h1, 32'h31});
      rchks('{rrd_pkg::A_MISC, rrd_pkg::A_CFG}, '{32'h2aa, 32'h11});
      rchk(rrd_pkg::A_STATUS, 32'h151);
   endtask
   // selected clear while not listen-addressed leaves no trace
   task automatic t_sdc_off();
      wrs('{rrd_pkg::A_IFACE, rrd_pkg::A_OQ}, '{32'h4, 32'h5});
      send_chk(3'h1, 10'b0000011110);
      rchk(rrd_pkg::A_OQ, 32'h5);
   endtask
   task automatic t_ifc();
      wrs('{rrd_pkg::A_IFACE, rrd_pkg::A_OQ, rrd_pkg::A_DISP, rrd_pkg::A_TRIG, rrd_pkg::A_ENA},
         '{32'h7, 32'h3, 32'h1, 32'h2, 32'h33});
      fork
         rrd_ctrl_model_inst.abort();
         begin
            repeat (5) @(posedge sys_clk);
            @(negedge sys_clk);
            chk_f(10'b0010011101);
         end
      join
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      chk_f(10'b0000011101);
      rchks('{rrd_pkg::A_OQ, rrd_pkg::A_DISP, rrd_pkg::A_TRIG}, '{32'h3, 32'h1, 32'h2});
      rchks('{rrd_pkg::A_ENA, rrd_pkg::A_IFACE}, '{32'h33, 32'h4});
   endtask
   // all three commands in one cycle: common reset, device clear, selected clear
   task automatic t_union();
      wrs('{rrd_pkg::A_IFACE, rrd_pkg::A_OQ, rrd_pkg::A_PEND, rrd_pkg::A_TRIG, rrd_pkg::A_EQ},
         '{32'h2, 32'h4, 32'h305, 32'h0, 32'h9});
      send_chk(3'h7, 10'b1100100011);
      rchks('{rrd_pkg::A_PEND, rrd_pkg::A_OQ, rrd_pkg::A_TRIG, rrd_pkg::A_EQ}, '{32'h0, 32'h0,
         32'h3, 32'h9});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      rchks('{rrd_pkg::A_PTF, 8'h3c}, '{32'hffffffff, 32'h0});
      t_rst();
      t_clear(3'h2);
      t_clear(3'h1);
      t_sdc_off();
      t_ifc();
      t_union();
      stop_test();
   end
   // whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      $display("[FAIL] watchdog expected finish seen timeout");
      stop_test();
   end
endmodule
